/* dv/pmca_board_model.sv */
`timescale 1ns/100ps
module pmca_board_model #(
  parameter int POR_CYC = 100
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clk_go,
  input  wire logic [7:0] want,
  input  wire logic [7:0] val,
  input  wire logic [7:0] cell_oe,
  output logic            clk_pin,
  output logic [7:0]      pin_in,
  output logic [7:0]      pin_ext_drive
);
  int         por_cnt;
  int         hi_cnt;
  logic [7:0] noise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt <= 0;
      hi_cnt  <= 0;
      clk_pin <= 1'b0;
    end else begin
      if (por_cnt < POR_CYC + 4) por_cnt <= por_cnt + 1;
      if (hi_cnt != 0) hi_cnt <= hi_cnt - 1;
      else if (clk_go && por_cnt >= POR_CYC + 4) hi_cnt <= 4;
      clk_pin <= (hi_cnt > 1);
    end
  end

  // floating pins show a pattern that changes every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) noise <= 8'h5a;
    else noise <= ~noise;
  end

  // board never fights a driving cell
  assign pin_ext_drive = want & ~cell_oe;
  assign pin_in        = (want & val) | (~want & noise);
endmodule

/* dv/pmca_macrocell_array_tb.sv */
`timescale 1ns/100ps
`include "pmca_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); end end
module pmca_macrocell_array_tb import pmca_pkg::*;;
  logic          aclk;
  logic          aresetn;
  logic [7:0]    awaddr, araddr, want, val, q, s, ex, eo, lv, fb, pre;
  logic          awvalid, awready, wvalid, wready, bvalid, bready, clk_go;
  logic          arvalid, arready, rvalid, rready, oe_n_pin, clk_pin;
  logic [31:0]   wdata, rdata;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, r;
  logic [63:0]   product_terms;
  logic [7:0]    pin_in, pin_ext_drive, cell_out, cell_oe, feedback;
  logic [15:0]   k;
  pmca_mode_type m;
  pmca_mode_type modes[3] = '{PMCA_MODE_REG, PMCA_MODE_CPLX, PMCA_MODE_SIMPLE};
  int            n_tests, n_mismatch, seed, cyc;

  // ==========================================================
  // clock, watchdog, instances
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  pmca_macrocell_array u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .product_terms(product_terms), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin),
    .pin_in(pin_in), .pin_ext_drive(pin_ext_drive), .cell_out(cell_out),
    .cell_oe(cell_oe), .feedback(feedback)
  );

  pmca_board_model u_board (
    .aclk(aclk), .aresetn(aresetn), .clk_go(clk_go), .want(want), .val(val),
    .cell_oe(cell_oe), .clk_pin(clk_pin), .pin_in(pin_in), .pin_ext_drive(pin_ext_drive)
  );

  // ==========================================================
  // bus tasks and expectations
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] mk,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK(rresp, er)
    `CHK(rdata & mk, ed)
  endtask

  // returns {oe, out} of one cell
  function automatic logic [1:0] cexp(pmca_mode_type md, logic [1:0] kd, logic [7:0] t,
                                      logic qb, logic oen, int i);
    if (md == PMCA_MODE_REG && kd == PMCA_KIND_REG) return {!oen, !qb};
    if (md == PMCA_MODE_SIMPLE)
      return {kd != PMCA_KIND_INPUT || i == `PMCA_CENTRE_LO || i == `PMCA_CENTRE_HI, |t};
    if (kd == PMCA_KIND_INPUT && !(md == PMCA_MODE_CPLX &&
        (i == `PMCA_OUTER_LO || i == `PMCA_OUTER_HI))) return {1'b0, |t[7:1]};
    return {t[0], |t[7:1]};
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {product_terms, want, val, clk_go, oe_n_pin, n_tests, n_mismatch, cyc} = '0;
    wstrb   = 4'hf;
    aresetn = 1'b0;
    seed    = 94540;
    q       = 8'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PMCA_OFF_STATUS, 32'h0002_0000, 32'h0003_00ff, `PMCA_RESP_OKAY);
    rd(`PMCA_OFF_CELLS, 32'h0000_0000, 32'h0000_ffff, `PMCA_RESP_OKAY);
    `CHK(cell_out, 8'hff)
    `CHK(cell_oe, 8'hff)
    rd(8'h20, 32'h0000_0000, 32'hffff_ffff, `PMCA_RESP_SLVERR);
    wr(8'h24, 32'h0000_0001, `PMCA_RESP_SLVERR);
    wr(`PMCA_OFF_MODE, 32'h0000_0001, `PMCA_RESP_OKAY);
    wr(`PMCA_OFF_MODE, 32'h0000_0002, `PMCA_RESP_OKAY);
    rd(`PMCA_OFF_MODE, 32'h0000_0001, 32'h0000_0003, `PMCA_RESP_OKAY);
    wr(`PMCA_OFF_MODE, 32'h0000_0000, `PMCA_RESP_OKAY);
    repeat (110) @(posedge aclk);
    rd(`PMCA_OFF_STATUS, 32'h0000_0000, 32'h0002_0000, `PMCA_RESP_OKAY);
    $display("test reset done");
    for (int n = 0; n < 4; n++) begin
      product_terms <= (n == 0) ? 64'h0 : (n == 1) ? '1 : {$random(seed), $random(seed)};
      repeat (6) @(posedge aclk);
      clk_go <= 1'b1;
      @(posedge aclk);
      clk_go <= 1'b0;
      repeat (12) @(posedge aclk);
      for (int i = 0; i < 8; i++) s[i] = |product_terms[8*i +: 8];
      q = s;
      `CHK(cell_out, ~s)
      rd(`PMCA_OFF_STATUS, {24'h0, s}, 32'h0000_00ff, `PMCA_RESP_OKAY);
    end
    $display("test clock done");
    for (int n = 0; n < 12; n++) begin
      m   = modes[n % 3];
      k   = (n < 3) ? 16'haaaa : 16'($random(seed));
      pre = 8'($random(seed));
      wr(`PMCA_OFF_MODE, {30'h0, m}, `PMCA_RESP_OKAY);
      wr(`PMCA_OFF_CELLS, {16'h0, k}, `PMCA_RESP_OKAY);
      wr(`PMCA_OFF_PRELOAD, {24'h0, pre}, `PMCA_RESP_OKAY);
      q = pre;
      product_terms <= {$random(seed), $random(seed)};
      want          <= 8'($random(seed));
      val           <= 8'($random(seed));
      oe_n_pin      <= 1'($random(seed));
      repeat (12) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        r     = cexp(m, k[2*i +: 2], product_terms[8*i +: 8], q[i], oe_n_pin, i);
        eo[i] = r[1];
        ex[i] = r[0];
        lv[i] = r[1] ? r[0] : (want[i] ? val[i] : 1'b1);
        fb[i] = (m == PMCA_MODE_REG && k[2*i +: 2] == PMCA_KIND_REG) ? q[i] : lv[i];
      end
      if (m != PMCA_MODE_REG) fb = {clk_pin, fb[6:1], oe_n_pin};
      if (m == PMCA_MODE_SIMPLE) fb[6:1] = {lv[7:5], lv[2:0]};
      `CHK(cell_out, ex)
      `CHK(cell_oe, eo)
      `CHK(feedback, fb)
      rd(`PMCA_OFF_VERIFY, {14'h0, m, k}, 32'h0003_ffff, `PMCA_RESP_OKAY);
    end
    $display("test config done");
    wr(`PMCA_OFF_SIG_LO, 32'h1234_5678, `PMCA_RESP_OKAY);
    wr(`PMCA_OFF_SIG_HI, 32'h9abc_def0, `PMCA_RESP_OKAY);
    wr(`PMCA_OFF_FUSE, 32'h0000_0001, `PMCA_RESP_OKAY);
    wr(`PMCA_OFF_PRELOAD, {24'h0, ~q}, `PMCA_RESP_SLVERR);
    rd(`PMCA_OFF_STATUS, {15'h0, 1'b1, 8'h0, q}, 32'h0001_00ff, `PMCA_RESP_OKAY);
    rd(`PMCA_OFF_VERIFY, 32'h0000_0000, 32'hffff_ffff, `PMCA_RESP_SLVERR);
    rd(`PMCA_OFF_SIG_LO, 32'h1234_5678, 32'hffff_ffff, `PMCA_RESP_OKAY);
    rd(`PMCA_OFF_SIG_HI, 32'h9abc_def0, 32'hffff_ffff, `PMCA_RESP_OKAY);
    $display("test secure done");
    conclude();
  end
endmodule

/* src/pmca_macrocell_array.sv */
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pmca_params.svh"
// Behaviour
// - reset clears registers low, outputs read high
// - preload forces each register high or low
// - secured device refuses verify and preload
// - user signature readable whether secured or not
// - undriven pins read high via pull-ups
// - eight cells, four configuration kinds each
// - one of three architecture modes at once
// - registered mode keeps clock and enable dedicated
// - complex mode feeds pins through outer cells
// - simple mode feeds back via neighbour cells
// - registered cell: pin clock, pin enable, eight terms
// - combinatorial cell: term enable, seven sum terms
// - input cell never drives its pin, except outer cells in complex mode and centre cells in simple mode
// - complex mode: seven terms, term enable
// - simple mode: eight terms, centre always enabled
module pmca_macrocell_array
  import pmca_pkg::*;
#(
  parameter int CELLS  = 8,
  parameter int TERMS  = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [ADDR_W-1:0]      awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [ADDR_W-1:0]      araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [CELLS*TERMS-1:0] product_terms,
  input  wire logic                   clk_pin,
  input  wire logic                   oe_n_pin,
  input  wire logic [CELLS-1:0]       pin_in,
  input  wire logic [CELLS-1:0]       pin_ext_drive,
  output logic [CELLS-1:0]            cell_out,
  output logic [CELLS-1:0]            cell_oe,
  output logic [CELLS-1:0]            feedback
);
  // ==========================================================
  // declarations
  localparam int SYN_W = 2 * CELLS + 2;
  logic [SYN_W-1:0]   sync1;
  logic [SYN_W-1:0]   sync2;
  logic               clk_s;
  logic               clk_prev;
  logic               oe_n_s;
  logic [CELLS-1:0]   pin_s;
  logic [CELLS-1:0]   ext_s;
  logic [CELLS-1:0]   pin_lvl;
  logic [7:0]         por_cnt;
  logic               por_busy;
  logic               clk_rise;
  pmca_mode_type      mode;
  logic [2*CELLS-1:0] cells;
  logic               secure;
  logic [63:0]        sig;
  logic [CELLS-1:0]   mreg;
  logic [CELLS-1:0]   sum;
  logic [CELLS-1:0]   next_out;
  logic [CELLS-1:0]   next_oe;
  logic [CELLS-1:0]   next_fb;
  logic [CELLS-1:0]   reg_mask;
  logic               aw_ok;
  logic               w_ok;
  logic [ADDR_W-1:0]  wa;
  logic [31:0]        wd;
  logic [3:0]         ws;
  logic               wr_do;
  logic               pre_do;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic pmca_kind_type kind_of(input logic [2*CELLS-1:0] c, input int i);
    return pmca_kind_type'(c[2*i +: 2]);
  endfunction

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge aclk) begin
    sync1 <= {clk_pin, oe_n_pin, pin_in, pin_ext_drive};
    sync2 <= sync1;
  end
  assign {clk_s, oe_n_s, pin_s, ext_s} = sync2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  always_comb begin
    for (int i = 0; i < CELLS; i++) begin
      pin_lvl[i] = cell_oe[i] ? cell_out[i] : (ext_s[i] ? pin_s[i] : 1'b1);
    end
  end

  // ==========================================================
  // power-up interval
  // clock edges ignored while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt <= 8'(`PMCA_POR_CYC);
    end else if (por_cnt != '0) begin
      por_cnt <= por_cnt - 8'd1;
    end
  end
  assign por_busy = (por_cnt != '0);
  assign clk_rise = clk_s && !clk_prev && !por_busy;

  // ==========================================================
  // AXI4-Lite write channel
  assign awready = !aw_ok && !bvalid;
  assign wready  = !w_ok && !bvalid;
  assign wr_do   = aw_ok && w_ok && !bvalid;
  assign pre_do  = wr_do && (wa == `PMCA_OFF_PRELOAD) && !secure && ws[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok  <= 1'b0;
      w_ok   <= 1'b0;
      wa     <= '0;
      wd     <= '0;
      ws     <= '0;
      bvalid <= 1'b0;
      bresp  <= `PMCA_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_ok <= 1'b1;
        wa    <= awaddr;
      end
      if (wvalid && wready) begin
        w_ok <= 1'b1;
        wd   <= wdata;
        ws   <= wstrb;
      end
      if (wr_do) begin
        aw_ok  <= 1'b0;
        w_ok   <= 1'b0;
        bvalid <= 1'b1;
        unique case (wa)
          `PMCA_OFF_MODE, `PMCA_OFF_CELLS, `PMCA_OFF_FUSE,
          `PMCA_OFF_SIG_LO, `PMCA_OFF_SIG_HI: bresp <= `PMCA_RESP_OKAY;
          `PMCA_OFF_PRELOAD: bresp <= secure ? `PMCA_RESP_SLVERR : `PMCA_RESP_OKAY;
          default: bresp <= `PMCA_RESP_SLVERR;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode  <= PMCA_MODE_REG;
      cells <= `PMCA_CELLS_RESET;
      sig   <= `PMCA_SIG_RESET;
    end else if (wr_do) begin
      if (wa == `PMCA_OFF_MODE && ws[0] && wd[1:0] != 2'b10) begin
        mode <= pmca_mode_type'(wd[1:0]);
      end
      if (wa == `PMCA_OFF_CELLS) begin
        cells <= 16'(merge({16'h0000, cells}, wd, ws));
      end
      if (wa == `PMCA_OFF_SIG_LO) begin
        sig[31:0] <= merge(sig[31:0], wd, ws);
      end
      if (wa == `PMCA_OFF_SIG_HI) begin
        sig[63:32] <= merge(sig[63:32], wd, ws);
      end
    end
  end

  // fuse sets once and stays set until reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secure <= 1'b0;
    end else if (wr_do && wa == `PMCA_OFF_FUSE && ws[0] && wd[0]) begin
      secure <= 1'b1;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `PMCA_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= `PMCA_RESP_OKAY;
      rdata  <= '0;
      unique case (araddr)
        `PMCA_OFF_MODE:  rdata[1:0] <= mode;
        `PMCA_OFF_CELLS: rdata[2*CELLS-1:0] <= cells;
        `PMCA_OFF_FUSE:  rdata[0] <= secure;
        `PMCA_OFF_VERIFY: begin
          if (secure) begin
            rresp <= `PMCA_RESP_SLVERR;
          end else begin
            rdata <= {14'h0000, mode, cells};
          end
        end
        `PMCA_OFF_PRELOAD: rdata[CELLS-1:0] <= mreg;
        `PMCA_OFF_SIG_LO: rdata <= sig[31:0];
        `PMCA_OFF_SIG_HI: rdata <= sig[63:32];
        `PMCA_OFF_STATUS: begin
          rdata[CELLS-1:0] <= mreg;
          rdata[`PMCA_ST_PIN_LSB +: CELLS] <= pin_lvl;
          rdata[`PMCA_ST_SECURE] <= secure;
          rdata[`PMCA_ST_POR] <= por_busy;
        end
        default: rresp <= `PMCA_RESP_SLVERR;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // macrocell logic
  // eight cells, kind per cell
  always_comb begin
    for (int i = 0; i < CELLS; i++) begin
      logic [TERMS-1:0] pt;
      pt = product_terms[i*TERMS +: TERMS];
      reg_mask[i] = (mode == PMCA_MODE_REG) && (kind_of(cells, i) == PMCA_KIND_REG);
      sum[i] = |pt;
      next_oe[i] = 1'b0;
      next_out[i] = |pt;
      unique case (mode)
        PMCA_MODE_REG: begin
          if (reg_mask[i]) begin
            // eight terms, pin enable, inverted register out
            next_out[i] = ~mreg[i];
            next_oe[i] = !oe_n_s;
          end else begin
            next_out[i] = |pt[TERMS-1:1];
            next_oe[i] = pt[0] && (kind_of(cells, i) != PMCA_KIND_INPUT);
          end
        end
        PMCA_MODE_CPLX: begin
          next_out[i] = |pt[TERMS-1:1];
          next_oe[i] = pt[0] && ((kind_of(cells, i) != PMCA_KIND_INPUT)
                       || i == `PMCA_OUTER_LO || i == `PMCA_OUTER_HI);
        end
        PMCA_MODE_SIMPLE: begin
          // no term enable, centre cells forced on
          next_oe[i] = (kind_of(cells, i) != PMCA_KIND_INPUT)
                       || i == `PMCA_CENTRE_LO || i == `PMCA_CENTRE_HI;
        end
        default: next_oe[i] = 1'b0;
      endcase
    end
  end

  // feedback routing into the array
  always_comb begin
    next_fb = pin_lvl;
    unique case (mode)
      PMCA_MODE_REG: begin
        // clock and enable pins never reach the array
        for (int i = 0; i < CELLS; i++) begin
          if (reg_mask[i]) begin
            next_fb[i] = mreg[i];
          end
        end
      end
      PMCA_MODE_CPLX: begin
        next_fb[`PMCA_OUTER_LO] = oe_n_s;
        next_fb[`PMCA_OUTER_HI] = clk_s;
      end
      PMCA_MODE_SIMPLE: begin
        // neighbour routing, outer cells carry enable and clock instead
        next_fb[`PMCA_OUTER_LO] = oe_n_s;
        next_fb[`PMCA_OUTER_HI] = clk_s;
        for (int i = 1; i < `PMCA_CENTRE_HI; i++) begin
          next_fb[i] = pin_lvl[i-1];
        end
        for (int i = `PMCA_CENTRE_HI; i < `PMCA_OUTER_HI; i++) begin
          next_fb[i] = pin_lvl[i+1];
        end
      end
      default: next_fb = pin_lvl;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mreg <= `PMCA_MREG_RESET;
    end else if (pre_do) begin
      mreg <= wd[CELLS-1:0];
    end else if (clk_rise) begin
      mreg <= (mreg & ~reg_mask) | (sum & reg_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_out <= '0;
      cell_oe  <= '0;
      feedback <= '0;
    end else begin
      cell_out <= next_out;
      cell_oe  <= next_oe;
      feedback <= next_fb;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_por_clear: assert property ($rose(aresetn) |-> mreg == '0 && por_busy)
    else $error("registers not clear after reset");
  chk_preload_load: assert property (pre_do |=> mreg == $past(wd[CELLS-1:0]))
    else $error("preload value not taken");
  chk_secure_refuse: assert property (
    wr_do && secure && wa == `PMCA_OFF_PRELOAD |=> bresp == `PMCA_RESP_SLVERR && bvalid)
    else $error("preload accepted while secured");
  chk_secure_sticky: assert property (secure |=> secure)
    else $error("security fuse cleared");
  chk_sig_read: assert property (
    arvalid && arready && araddr == `PMCA_OFF_SIG_LO |=> rdata == $past(sig[31:0]))
    else $error("signature read wrong");
  chk_pull_up: assert property (&(pin_lvl | cell_oe | ext_s))
    else $error("idle pin not high");
  chk_centre_on: assert property (
    mode == PMCA_MODE_SIMPLE ##1 mode == PMCA_MODE_SIMPLE |->
      &cell_oe[`PMCA_CENTRE_HI:`PMCA_CENTRE_LO])
    else $error("centre cell disabled");
  chk_cplx_fb: assert property (
    mode == PMCA_MODE_CPLX |=> feedback[`PMCA_OUTER_HI] == $past(clk_s))
    else $error("clock pin not on outer feedback");
  chk_reg_load: assert property (
    clk_rise && !pre_do |=> (mreg & $past(reg_mask)) == $past(sum & reg_mask))
    else $error("registered cells not loaded");
  chk_input_off: assert property (
    mode == PMCA_MODE_REG && kind_of(cells, 1) == PMCA_KIND_INPUT |=> !cell_oe[1])
    else $error("input cell driving");

  cov_preload: cover property (pre_do ##1 clk_rise);
  cov_secure: cover property (secure ##[1:20] rvalid && rresp == `PMCA_RESP_SLVERR);
  cov_simple: cover property (mode == PMCA_MODE_SIMPLE ##1 |cell_oe);
endmodule

/* src/pmca_params.svh */
`ifndef PMCA_PARAMS_SVH
`define PMCA_PARAMS_SVH
// ==========================================================
// register offsets (byte addresses)
`define PMCA_OFF_MODE    8'h00
`define PMCA_OFF_CELLS   8'h04
`define PMCA_OFF_FUSE    8'h08
`define PMCA_OFF_PRELOAD 8'h0C
`define PMCA_OFF_VERIFY  8'h10
`define PMCA_OFF_SIG_LO  8'h14
`define PMCA_OFF_SIG_HI  8'h18
`define PMCA_OFF_STATUS  8'h1C
// ==========================================================
// field positions and reset values
`define PMCA_ST_PIN_LSB  8
`define PMCA_ST_SECURE   16
`define PMCA_ST_POR      17
`define PMCA_MREG_RESET  8'h00
`define PMCA_SIG_RESET   64'h0000_0000_0000_0000
`define PMCA_CELLS_RESET 16'h0000
// ==========================================================
// cell positions
`define PMCA_OUTER_LO    0
`define PMCA_OUTER_HI    7
`define PMCA_CENTRE_LO   3
`define PMCA_CENTRE_HI   4
// ==========================================================
// bus answers and timing
`define PMCA_RESP_OKAY   2'b00
`define PMCA_RESP_SLVERR 2'b10
`define PMCA_CLK_NS      10
`define PMCA_POR_NS      1000
`define PMCA_POR_CYC     (`PMCA_POR_NS / `PMCA_CLK_NS)
`endif

/* src/pmca_pkg.sv */
package pmca_pkg;
  typedef enum logic [1:0] {
    PMCA_MODE_REG    = 2'b00,
    PMCA_MODE_CPLX   = 2'b01,
    PMCA_MODE_SIMPLE = 2'b11
  } pmca_mode_type;
  typedef enum logic [1:0] {
    PMCA_KIND_REG   = 2'b00,
    PMCA_KIND_IO    = 2'b01,
    PMCA_KIND_OUT   = 2'b11,
    PMCA_KIND_INPUT = 2'b10
  } pmca_kind_type;
endpackage
